// file: logic/cbw_pkg.sv
// Constants, register map and field helpers for the CAN board window decoder
// Behaviour
// - claim one 256-byte window at the base
// - host address bit A19 must be one
// - compare A18..A8 against eleven base selections
// - fitted jumper reads one, absent reads zero
// - top four selections pick 32 KB regions
// - default window base is D0000
// - controller interrupt drives one selected channel, default 5
// - interrupt channel is never shared, driven exclusively
// - clock select chooses 8 or 16 MHz, default 8
package cbw_pkg;

  localparam int APB_AW = 12;
  localparam int DW = 32;
  localparam int HOST_AW = 20;
  localparam int BASE_W = 11;
  localparam int IRQ_W = 4;
  localparam int IRQ_N = 16;
  localparam int HDW = 8;

  // Window decode positions on the host address
  localparam int WIN_A19 = 19;
  localparam int WIN_MSB = 18;
  localparam int WIN_LSB = 8;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFF_CFG = 12'h000;
  localparam logic [APB_AW-1:0] OFF_STAT = 12'h004;
  localparam logic [APB_AW-1:0] OFF_CLR = 12'h008;
  localparam logic [APB_AW-1:0] OFF_EN = 12'h00C;
  localparam logic [APB_AW-1:0] OFF_STRAP = 12'h010;
  localparam logic [APB_AW-1:0] OFF_ACT = 12'h014;

  // Configuration word layout
  localparam int CFG_BASE_LSB = 0;
  localparam int CFG_IRQ_LSB = 16;
  localparam int CFG_CLK_BIT = 24;
  localparam int CFG_SRC_BIT = 31;

  // Factory defaults: base pattern 1010_0000000 is D0000
  localparam logic [BASE_W-1:0] BASE_DEFAULT = 11'h500;
  localparam logic [IRQ_W-1:0] IRQ_DEFAULT = 4'h5;
  localparam logic CLK_8MHZ = 1'b0;
  localparam logic CLK_16MHZ = 1'b1;

  // Event bits
  localparam int EV_W = 4;
  localparam int EV_CAN_INT = 0;
  localparam int EV_HOST_RD = 1;
  localparam int EV_HOST_WR = 2;
  localparam int EV_ABORT = 3;

  function automatic logic [DW-1:0] pack_cfg(input logic [BASE_W-1:0] base,
                                             input logic [IRQ_W-1:0] irq,
                                             input logic clk_sel,
                                             input logic src);
    logic [DW-1:0] w;
    w = '0;
    w[CFG_BASE_LSB +: BASE_W] = base;
    w[CFG_IRQ_LSB +: IRQ_W] = irq;
    w[CFG_CLK_BIT] = clk_sel;
    w[CFG_SRC_BIT] = src;
    return w;
  endfunction : pack_cfg

  function automatic logic [BASE_W-1:0] cfg_base(input logic [DW-1:0] w);
    return w[CFG_BASE_LSB +: BASE_W];
  endfunction : cfg_base

  function automatic logic [IRQ_W-1:0] cfg_irq(input logic [DW-1:0] w);
    return w[CFG_IRQ_LSB +: IRQ_W];
  endfunction : cfg_irq

  localparam logic [DW-1:0] CFG_RESET = pack_cfg(BASE_DEFAULT, IRQ_DEFAULT, CLK_8MHZ, 1'b0);

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_READ,
    HS_WRITE
  } cbw_host_state_t;

endpackage : cbw_pkg

// file: logic/cbw_sel_if.sv
// Selection and decode signals shared between the top and its helpers
`timescale 1ns/1ps
interface cbw_sel_if;
  import cbw_pkg::*;
  logic [BASE_W-1:0] base_sel;
  logic [IRQ_W-1:0] irq_sel;
  logic irq_req;
  logic hit;
  modport ctrl (output base_sel, output irq_sel, output irq_req, input hit);
  modport dec (input base_sel, output hit);
  modport route (input irq_sel, input irq_req);
endinterface : cbw_sel_if

// file: logic/cbw_window_decode.sv
// Host memory window decoder
`timescale 1ns/1ps
module cbw_window_decode
  import cbw_pkg::*;
(
  // Host address
  input wire logic [HOST_AW-1:0] host_addr,
  // Selection in, hit out
  cbw_sel_if.dec sel
);

  // A19 is forced, A18..A8 must equal the selection; A7..A0 index 256 bytes
  always_comb begin
    sel.hit = host_addr[WIN_A19]
      && (host_addr[WIN_MSB:WIN_LSB] == sel.base_sel);
  end

endmodule : cbw_window_decode

// file: logic/cbw_irq_route.sv
// Routes the controller interrupt onto one host interrupt channel
`timescale 1ns/1ps
module cbw_irq_route
  import cbw_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Selection and request
  cbw_sel_if.route sel,
  // Host interrupt channels
  output logic [IRQ_N-1:0] host_irq_o,
  output logic [IRQ_N-1:0] host_irq_oe
);

  // One-hot enable: only the chosen channel is ever driven
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      host_irq_oe <= '0;
    end else begin
      host_irq_oe <= IRQ_N'(1) << sel.irq_sel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      host_irq_o <= '0;
    end else begin
      host_irq_o <= (IRQ_N'(1) << sel.irq_sel) & {IRQ_N{sel.irq_req}};
    end
  end

endmodule : cbw_irq_route

// file: logic/cbw_top.sv
// Host attachment of the CAN board: window decode, strobes, interrupt, APB registers
`timescale 1ns/1ps
module cbw_top
  import cbw_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  output logic [DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt to the local processor
  output logic irq,
  // Jumper inputs, one when fitted
  input wire logic [BASE_W-1:0] base_jumper,
  input wire logic [IRQ_W-1:0] irq_jumper,
  input wire logic controller_clock_select,
  // Host memory bus
  input wire logic [HOST_AW-1:0] host_addr,
  input wire logic host_memr_n,
  input wire logic host_memw_n,
  input wire logic [HDW-1:0] host_data_i,
  output logic [HDW-1:0] host_data_o,
  output logic host_data_oe,
  // Host interrupt channels
  output logic [IRQ_N-1:0] host_irq_o,
  output logic [IRQ_N-1:0] host_irq_oe,
  // CAN controller side
  output logic ctl_cs_n,
  output logic ctl_rd_n,
  output logic ctl_wr_n,
  output logic [HDW-1:0] ctl_addr,
  output logic [HDW-1:0] ctl_wdata,
  input wire logic [HDW-1:0] ctl_rdata,
  input wire logic ctl_int_n,
  output logic ctl_clk_sel
);

  cbw_sel_if sel ();

  logic [DW-1:0] cfg_reg;
  logic [DW-1:0] strap_reg;
  logic [EV_W-1:0] stat_reg;
  logic [EV_W-1:0] stat_next;
  logic [EV_W-1:0] en_reg;
  logic [EV_W-1:0] clr_mask;
  logic [EV_W-1:0] events;
  logic [DW-1:0] act_word;
  logic [DW-1:0] rd_word;
  logic rd_ok;
  logic wr_acc;
  logic can_int_reg;
  logic can_int_prev_reg;
  logic clk_sel_reg;
  cbw_host_state_t hs_reg;
  cbw_host_state_t hs_next;
  logic rd_req;
  logic wr_req;

  // Helpers
  cbw_window_decode u_dec (
    .host_addr(host_addr),
    .sel(sel.dec)
  );

  cbw_irq_route u_irq (
    .clk_sys(clk_sys),
    .srst(srst),
    .sel(sel.route),
    .host_irq_o(host_irq_o),
    .host_irq_oe(host_irq_oe)
  );

  // APB: zero wait states, every access completes in its access phase
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;

  // Configuration register; reset gives the factory window and channel
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_acc && paddr == OFF_CFG) begin
      cfg_reg <= pack_cfg(cfg_base(pwdata), cfg_irq(pwdata),
                          pwdata[CFG_CLK_BIT], pwdata[CFG_SRC_BIT]);
    end
  end

  // Jumpers are static; they are sampled every cycle and read back as fitted = one
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      strap_reg <= '0;
    end else begin
      strap_reg <= pack_cfg(base_jumper, irq_jumper, controller_clock_select, 1'b1);
    end
  end

  // The source bit picks jumpers or the software copy of the defaults
  always_comb begin
    if (cfg_reg[CFG_SRC_BIT]) begin
      act_word = strap_reg;
    end else begin
      act_word = cfg_reg;
    end
  end

  assign sel.base_sel = cfg_base(act_word);
  assign sel.irq_sel = cfg_irq(act_word);

  // Controller clock choice is a registered static level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clk_sel_reg <= CLK_8MHZ;
    end else begin
      clk_sel_reg <= act_word[CFG_CLK_BIT];
    end
  end

  assign ctl_clk_sel = clk_sel_reg;

  // Controller interrupt is active low; registered before routing
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      can_int_reg <= 1'b0;
    end else begin
      can_int_reg <= !ctl_int_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      can_int_prev_reg <= 1'b0;
    end else begin
      can_int_prev_reg <= can_int_reg;
    end
  end

  assign sel.irq_req = can_int_reg;

  // Host cycle tracking; a request only counts while the window is hit
  assign rd_req = sel.hit && !host_memr_n;
  assign wr_req = sel.hit && !host_memw_n;

  // A read wins over a write when both strobes fall together; it cannot alter the controller
  always_comb begin
    hs_next = hs_reg;
    case (hs_reg)
      HS_IDLE: begin
        if (rd_req) begin
          hs_next = HS_READ;
        end else if (wr_req) begin
          hs_next = HS_WRITE;
        end
      end
      HS_READ: begin
        if (!rd_req) begin
          hs_next = HS_IDLE;
        end
      end
      HS_WRITE: begin
        if (!wr_req) begin
          hs_next = HS_IDLE;
        end
      end
      default: begin
        hs_next = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hs_reg <= HS_IDLE;
    end else begin
      hs_reg <= hs_next;
    end
  end

  // Controller strobes follow the next state so they drop as soon as the cycle leaves
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl_cs_n <= 1'b1;
      ctl_rd_n <= 1'b1;
      ctl_wr_n <= 1'b1;
    end else begin
      ctl_cs_n <= (hs_next == HS_IDLE);
      ctl_rd_n <= (hs_next != HS_READ);
      ctl_wr_n <= (hs_next != HS_WRITE);
    end
  end

  // Offset within the 256-byte window and write data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl_addr <= '0;
      ctl_wdata <= '0;
    end else if (rd_req || wr_req) begin
      ctl_addr <= host_addr[HDW-1:0];
      ctl_wdata <= host_data_i;
    end
  end

  // Host data is driven only during a claimed read
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      host_data_oe <= 1'b0;
    end else begin
      host_data_oe <= (hs_next == HS_READ);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      host_data_o <= '0;
    end else if (hs_reg == HS_READ) begin
      host_data_o <= ctl_rdata;
    end
  end

  // Events: controller interrupt rising, host read, host write, cycle dropped by address
  always_comb begin
    events = '0;
    events[EV_CAN_INT] = can_int_reg && !can_int_prev_reg;
    events[EV_HOST_RD] = (hs_reg == HS_IDLE) && (hs_next == HS_READ);
    events[EV_HOST_WR] = (hs_reg == HS_IDLE) && (hs_next == HS_WRITE);
    events[EV_ABORT] = (hs_reg != HS_IDLE) && !sel.hit
      && !(host_memr_n && host_memw_n);
  end

  // Write-one-to-clear; an event in the clearing cycle still sets its bit
  always_comb begin
    clr_mask = '0;
    if (wr_acc && paddr == OFF_CLR) begin
      clr_mask = pwdata[EV_W-1:0];
    end
    stat_next = (stat_reg & ~clr_mask) | events;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_reg <= '0;
    end else if (wr_acc && paddr == OFF_EN) begin
      en_reg <= pwdata[EV_W-1:0];
    end
  end

  // Level output; only clearing the status or the enable drops it
  assign irq = |(stat_reg & en_reg);

  // Read decode; the clear register reads as zero, unmapped offsets error
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (paddr)
      OFF_CFG: begin
        rd_word = cfg_reg;
      end
      OFF_STAT: begin
        rd_word[EV_W-1:0] = stat_reg;
      end
      OFF_CLR: begin
        rd_word = '0;
      end
      OFF_EN: begin
        rd_word[EV_W-1:0] = en_reg;
      end
      OFF_STRAP: begin
        rd_word = strap_reg;
      end
      OFF_ACT: begin
        rd_word = pack_cfg(sel.base_sel, sel.irq_sel, clk_sel_reg, cfg_reg[CFG_SRC_BIT]);
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read data is captured in the setup phase, so the access phase still needs no wait
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

  // Unmapped offsets answer with an error in the access phase; their writes are dropped
  assign pslverr = psel && penable && !rd_ok;

endmodule : cbw_top

// file: bench/cbw_monitor.sv
// Checker on the host window and interrupt pins
`timescale 1ns/1ps
module cbw_monitor
  import cbw_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Host bus
  input wire logic [HOST_AW-1:0] host_addr,
  input wire logic host_memr_n,
  input wire logic host_memw_n,
  input wire logic host_data_oe,
  input wire logic [IRQ_N-1:0] host_irq_o,
  input wire logic [IRQ_N-1:0] host_irq_oe,
  // Controller side
  input wire logic ctl_cs_n,
  input wire logic ctl_rd_n,
  input wire logic ctl_wr_n,
  input wire logic [HDW-1:0] ctl_addr,
  input wire logic ctl_int_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_no_a19: assert property (!host_addr[WIN_A19] |=> ctl_cs_n && !host_data_oe)
    else $error("claim with A19 low");
  a_oe_release: assert property (host_memr_n |=> !host_data_oe)
    else $error("data driven without read");
  a_oe_read_only: assert property (host_data_oe |-> !ctl_rd_n && !ctl_cs_n)
    else $error("data driven outside claimed read");
  a_offset_route: assert property (!ctl_cs_n |-> ctl_addr == $past(host_addr[7:0]))
    else $error("window offset wrong");
  // First edge after reset still shows the cleared enable
  a_chan_onehot: assert property (!$past(srst) |-> $onehot(host_irq_oe))
    else $error("not one channel enabled");
  a_chan_exclusive: assert property ((host_irq_o & ~host_irq_oe) == '0)
    else $error("unselected channel driven");
  a_irq_raise: assert property (!ctl_int_n [*2] |=> (host_irq_o & host_irq_oe) != '0)
    else $error("interrupt not routed");
  a_irq_drop: assert property (ctl_int_n [*2] |=> host_irq_o == '0)
    else $error("interrupt stuck");
  c_read: cover property (!ctl_rd_n);
  c_write: cover property (!ctl_wr_n);
  c_irq: cover property (host_irq_o != '0);
endmodule : cbw_monitor
bind cbw_top cbw_monitor u_mon (.clk_sys, .srst, .host_addr, .host_memr_n, .host_memw_n,
  .host_data_oe, .host_irq_o, .host_irq_oe, .ctl_cs_n, .ctl_rd_n, .ctl_wr_n, .ctl_addr,
  .ctl_int_n);

// file: bench/cbw_host_model.sv
// Host processor model driving memory cycles
`timescale 1ns/1ps
module cbw_host_model
  import cbw_pkg::*;
#(
  parameter bit AT_BUS = 1'b1
)
(
  // Clock
  input wire logic clk_sys,
  // Host bus
  output logic [HOST_AW-1:0] host_addr,
  output logic host_memr_n,
  output logic host_memw_n,
  output logic [HDW-1:0] host_data_i,
  input wire logic [HDW-1:0] host_data_o,
  input wire logic host_data_oe
);
  initial begin
    host_addr = '0;
    host_memr_n = 1'b1;
    host_memw_n = 1'b1;
    host_data_i = 8'h00;
  end
  // Upper channels need the AT extension; each channel serves one board
  function automatic bit chan_ok(input logic [IRQ_W-1:0] ch);
    return AT_BUS || ch < 4'hA;
  endfunction : chan_ok
  // Fixed cycle length, as the bus has no ready line from this board
  task automatic cyc(input logic w, input logic [HOST_AW-1:0] a, input logic [HDW-1:0] d,
                     output logic [HDW-1:0] q, output logic hit);
    host_addr <= a;
    host_data_i <= w ? d : ~host_data_i;
    host_memr_n <= w;
    host_memw_n <= !w;
    repeat (4) @(posedge clk_sys);
    q = host_data_o;
    hit = host_data_oe;
    host_memr_n <= 1'b1;
    host_memw_n <= 1'b1;
    // Released data lines must not keep the last value
    host_data_i <= ~host_data_i;
    repeat (2) @(posedge clk_sys);
  endtask : cyc
  // Read whose address moves off the window while the strobe is still low
  task automatic drift(input logic [HOST_AW-1:0] a);
    host_addr <= a;
    host_memr_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    host_addr <= a ^ 20'h00100;
    repeat (2) @(posedge clk_sys);
    host_memr_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : drift
endmodule : cbw_host_model

// file: bench/tb_top.sv
// Self-checking bench for the CAN board host attachment
`timescale 1ns/1ps
module tb_top;
  import cbw_pkg::*;
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, irq, err, hit;
  logic controller_clock_select, host_memr_n, host_memw_n, host_data_oe;
  logic ctl_cs_n, ctl_rd_n, ctl_wr_n, ctl_int_n, ctl_clk_sel;
  logic [APB_AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, rd;
  logic [BASE_W-1:0] base_jumper;
  logic [IRQ_W-1:0] irq_jumper;
  logic [HOST_AW-1:0] host_addr;
  logic [HDW-1:0] host_data_i, host_data_o, ctl_addr, ctl_wdata, ctl_rdata, q;
  logic [IRQ_N-1:0] host_irq_o, host_irq_oe;
  logic [15:0] wseen = '0;
  int fail_count, checked;
  cbw_top DUT (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .base_jumper, .irq_jumper, .controller_clock_select, .host_addr,
    .host_memr_n, .host_memw_n, .host_data_i, .host_data_o, .host_data_oe, .host_irq_o,
    .host_irq_oe, .ctl_cs_n, .ctl_rd_n, .ctl_wr_n, .ctl_addr, .ctl_wdata, .ctl_rdata,
    .ctl_int_n, .ctl_clk_sel);
  cbw_host_model host (.clk_sys, .host_addr, .host_memr_n, .host_memw_n, .host_data_i,
    .host_data_o, .host_data_oe);
  // Controller answers with a byte tied to its offset
  assign ctl_rdata = ctl_addr ^ 8'hA5;
  always @(posedge clk_sys) begin
    if (!ctl_wr_n) begin
      wseen <= {ctl_addr, ctl_wdata};
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [DW-1:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic do_reset;
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
  endtask : do_reset
  task automatic t_reset;
    apb(1'b0, OFF_CFG, '0);
    chk(rd, 32'h0005_0500);
    apb(1'b0, OFF_STRAP, '0);
    chk(rd, 32'h8109_03A5);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    chk(host_irq_oe, 16'h0020);
    chk(ctl_clk_sel, 1'b0);
  endtask : t_reset
  task automatic t_window;
    logic [HOST_AW-1:0] ad [5];
    ad = '{20'hD0000, 20'hD00FF, 20'hD0100, 20'hCFFFF, 20'h500FF};
    for (int i = 0; i < 5; i++) begin
      host.cyc(1'b0, ad[i], 8'h00, q, hit);
      chk(hit, i < 2);
      if (i < 2) begin
        chk(q, ad[i][7:0] ^ 8'hA5);
      end
    end
    host.cyc(1'b1, 20'hD0042, 8'h5C, q, hit);
    chk(wseen, 16'h425C);
    host.cyc(1'b1, 20'h50043, 8'h3B, q, hit);
    chk(wseen, 16'h425C);
    host.drift(20'hD0010);
    apb(1'b0, OFF_STAT, '0);
    chk(rd, (32'h1 << EV_HOST_RD) | (32'h1 << EV_HOST_WR) | (32'h1 << EV_ABORT));
  endtask : t_window
  task automatic t_irq;
    apb(1'b1, OFF_EN, 32'h1);
    ctl_int_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b1);
    chk(host_irq_o, 16'h0020);
    ctl_int_n <= 1'b1;
    apb(1'b1, OFF_CLR, 32'hF);
    apb(1'b0, OFF_STAT, '0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, OFF_EN, 32'h0);
    ctl_int_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b0);
    ctl_int_n <= 1'b1;
    apb(1'b0, OFF_STAT, '0);
    chk(rd, 32'h1);
  endtask : t_irq
  // Straps are static, so each setting is taken through a reset
  task automatic t_straps;
    for (int k = 0; k < 16; k++) begin
      if (host.chan_ok(k[3:0])) begin
        base_jumper <= {k[3:0], 7'h0E};
        irq_jumper <= k[3:0];
        controller_clock_select <= k[0];
        do_reset;
        apb(1'b1, OFF_CFG, 32'h8000_0000);
        host.cyc(1'b0, {1'b1, k[3:0], 7'h0E, 8'h33}, 8'h00, q, hit);
        chk(hit, 1'b1);
        host.cyc(1'b0, {1'b1, k[3:0], 7'h0F, 8'h33}, 8'h00, q, hit);
        chk(hit, 1'b0);
        chk(ctl_clk_sel, k[0]);
        ctl_int_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(host_irq_o, 16'h1 << k);
        chk(host_irq_oe, 16'h1 << k);
        ctl_int_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
      end
    end
  endtask : t_straps
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    base_jumper = 11'h3A5;
    irq_jumper = 4'h9;
    controller_clock_select = 1'b1;
    ctl_int_n = 1'b1;
    fail_count = 0;
    checked = 0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_window;
    t_irq;
    t_straps;
    wrap_up;
  end
  // The whole sequence needs about five hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    wrap_up;
  end
endmodule : tb_top
